// >>> core/sfw_core.sv
// Overview of operation
// - Decode 06h as latch set and 04h as latch clear.
// - Decode 03h as array read, 0Bh fast read, 02h array write.
// - Decode B9h as sleep entry and 9Fh as ident read.
// - Status read shifts out the status byte, most significant bit first.
// - Write latch is clear after power-up; everything starts write-disabled.
// - Latch set command sets the latch, shown at status bit 1.
// - Status write data never changes the write latch.
// - Latch clears at chip-select rise ending status or array write; clear opcode clears it at its eighth bit.
// - Latch clear command disables all writes until set again.
// - Protect pin enable at bit 7, guard bits at 3 and 2.
// - Status bits 0 and 4 to 6 ignore writes; bits 4 to 6 read zero.
// - Bit 0 may read one only while waking from sleep.
// - Guard bits are kept in nonvolatile storage across power cycles.
// - Guard 01 protects upper quarter, 10 upper half, 11 all.
// - Array writes blocked only by clear latch or guarded address.
// - Status writes refused when pin enable set and pin low.
// - Guarded blocks never writable; clear latch blocks array and status.
// - Status write takes one byte updating pin enable and guard bits.
// - First byte after chip-select fall is the opcode, MSB first.
// - Undefined opcode: ignore input until next fall, output stays off.
// - Burst write reaching a guarded address stops and drops the rest.
`timescale 1ns/100ps

module sfw_core (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                spi_sck,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_si,
  input  wire logic                protect_pin_n,
  input  wire logic                wake_busy,
  input  wire logic [1:0]          nv_guard_in,
  output logic                     spi_so,
  output logic                     spi_so_oe,
  output sfw_pkg::sfw_wr_t         array_wr,
  output logic                     array_wr_refused,
  output logic                     status_wr_refused,
  output sfw_pkg::sfw_cmd_t        cmd,
  output logic                     sleep_req,
  output logic                     nv_guard_wr,
  output logic [1:0]               nv_guard_out,
  output logic                     write_latch_flag,
  output logic                     protect_pin_enable
);

  localparam sfw_pkg::sfw_core_t CORE_RST = '{
    state:          sfw_pkg::ST_IDLE,
    prev:           sfw_pkg::PINS_IDLE,
    bit_cnt:        3'h0,
    sh_in:          8'h00,
    sh_out:         8'h00,
    addr:           14'h0000,
    addr_lo:        1'b0,
    wr_stop:        1'b0,
    end_clear:      1'b0,
    end_sleep:      1'b0,
    latch:          sfw_pkg::RST_LATCH,
    pen:            sfw_pkg::RST_PEN,
    guard:          sfw_pkg::RST_GUARD,
    nv_loaded:      1'b0,
    so:             1'b0,
    so_oe:          1'b0,
    wr:             '{valid: 1'b0, addr: 14'h0000, data: 8'h00},
    wr_refused:     1'b0,
    status_refused: 1'b0,
    nv_wr:          1'b0,
    cmd:            '{valid: 1'b0, kind: sfw_pkg::CMD_NONE},
    sleep_req:      1'b0
  };

  sfw_pkg::sfw_core_t r_reg;
  sfw_pkg::sfw_core_t r_next;
  sfw_pkg::sfw_pins_t pins;
  sfw_pkg::sfw_pins_t pins_raw;

  // Raw pins grouped before the synchroniser
  assign pins_raw = '{sck: spi_sck, cs_n: spi_cs_n, si: spi_si,
                      wp_n: protect_pin_n};

  sfw_pin_sync u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  function automatic logic guarded(input logic [1:0]  g,
                                   input logic [13:0] a);
    case (g)
      sfw_pkg::GUARD_QUARTER: guarded = (a >= sfw_pkg::QUARTER_BASE);
      sfw_pkg::GUARD_HALF:    guarded = (a >= sfw_pkg::HALF_BASE);
      sfw_pkg::GUARD_ALL:     guarded = 1'b1;
      default:                guarded = 1'b0;
    endcase
  endfunction

  always_comb begin
    logic [7:0] sh_v;
    logic       byte_done;
    logic [7:0] st_v;
    logic       cs_fall;
    logic       cs_rise;
    logic       sck_rise;
    logic       sck_fall;
    sh_v      = 8'h00;
    byte_done = 1'b0;
    st_v      = 8'h00;
    cs_fall   = r_reg.prev.cs_n & ~pins.cs_n;
    cs_rise   = ~r_reg.prev.cs_n & pins.cs_n;
    sck_rise  = ~r_reg.prev.sck & pins.sck & ~pins.cs_n;
    sck_fall  = r_reg.prev.sck & ~pins.sck & ~pins.cs_n;

    r_next                = r_reg;
    r_next.prev           = pins;
    r_next.wr.valid       = 1'b0;
    r_next.wr_refused     = 1'b0;
    r_next.status_refused = 1'b0;
    r_next.nv_wr          = 1'b0;
    r_next.cmd.valid      = 1'b0;
    r_next.sleep_req      = 1'b0;

    st_v[sfw_pkg::BIT_PEN]   = r_reg.pen;
    st_v[sfw_pkg::BIT_GHI]   = r_reg.guard[1];
    st_v[sfw_pkg::BIT_GLO]   = r_reg.guard[0];
    st_v[sfw_pkg::BIT_LATCH] = r_reg.latch;
    st_v[sfw_pkg::BIT_WAKE]  = wake_busy;

    if (!r_reg.nv_loaded) begin
      r_next.guard     = nv_guard_in;
      r_next.nv_loaded = 1'b1;
    end

    if (cs_fall) begin
      r_next.state     = sfw_pkg::ST_OPCODE;
      r_next.bit_cnt   = 3'h0;
      r_next.addr_lo   = 1'b0;
      r_next.wr_stop   = 1'b0;
      r_next.end_clear = 1'b0;
      r_next.end_sleep = 1'b0;
      r_next.so_oe     = 1'b0;
    end else if (cs_rise) begin
      r_next.state = sfw_pkg::ST_IDLE;
      r_next.so_oe = 1'b0;
      if (r_reg.end_clear) begin
        r_next.latch = 1'b0;
      end
      r_next.sleep_req = r_reg.end_sleep;
    end else if (sck_fall) begin
      if (r_reg.state == sfw_pkg::ST_SRD) begin
        r_next.so     = r_reg.sh_out[7];
        r_next.so_oe  = 1'b1;
        r_next.sh_out = {r_reg.sh_out[6:0], r_reg.sh_out[7]};
      end
    end else if (sck_rise) begin
      sh_v           = {r_reg.sh_in[6:0], pins.si};
      byte_done      = (r_reg.bit_cnt == sfw_pkg::BIT_LAST);
      r_next.sh_in   = sh_v;
      r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
      case (r_reg.state)
        sfw_pkg::ST_OPCODE: begin
          if (byte_done) begin
            r_next.cmd.valid = 1'b1;
            r_next.state     = sfw_pkg::ST_SKIP;
            case (sh_v)
              sfw_pkg::OP_SET_LATCH: begin
                r_next.latch    = 1'b1;
                r_next.cmd.kind = sfw_pkg::CMD_SET_LATCH;
              end
              sfw_pkg::OP_CLR_LATCH: begin
                r_next.latch     = 1'b0;
                r_next.end_clear = 1'b1;
                r_next.cmd.kind  = sfw_pkg::CMD_CLR_LATCH;
              end
              sfw_pkg::OP_STATUS_RD: begin
                r_next.state    = sfw_pkg::ST_SRD;
                r_next.sh_out   = st_v;
                r_next.cmd.kind = sfw_pkg::CMD_STATUS_RD;
              end
              sfw_pkg::OP_STATUS_WR: begin
                r_next.state     = sfw_pkg::ST_SWR;
                r_next.end_clear = 1'b1;
                r_next.cmd.kind  = sfw_pkg::CMD_STATUS_WR;
              end
              sfw_pkg::OP_ARRAY_RD: begin
                r_next.cmd.kind = sfw_pkg::CMD_ARRAY_RD;
              end
              sfw_pkg::OP_FAST_RD: begin
                r_next.cmd.kind = sfw_pkg::CMD_FAST_RD;
              end
              sfw_pkg::OP_ARRAY_WR: begin
                r_next.state     = sfw_pkg::ST_ADDR;
                r_next.end_clear = 1'b1;
                r_next.cmd.kind  = sfw_pkg::CMD_ARRAY_WR;
              end
              sfw_pkg::OP_SLEEP: begin
                r_next.end_sleep = 1'b1;
                r_next.cmd.kind  = sfw_pkg::CMD_SLEEP;
              end
              sfw_pkg::OP_IDENT: begin
                r_next.cmd.kind = sfw_pkg::CMD_IDENT;
              end
              default: begin
                r_next.cmd.kind = sfw_pkg::CMD_INVALID;
              end
            endcase
          end
        end
        sfw_pkg::ST_ADDR: begin
          if (byte_done) begin
            // Upper two address bits are dropped
            if (!r_reg.addr_lo) begin
              r_next.addr[13:8] = sh_v[5:0];
              r_next.addr_lo    = 1'b1;
            end else begin
              r_next.addr[7:0] = sh_v;
              r_next.state     = sfw_pkg::ST_WDATA;
            end
          end
        end
        sfw_pkg::ST_WDATA: begin
          if (byte_done && !r_reg.wr_stop) begin
            if (r_reg.latch && !guarded(r_reg.guard, r_reg.addr)) begin
              r_next.wr.valid = 1'b1;
              r_next.wr.addr  = r_reg.addr;
              r_next.wr.data  = sh_v;
              r_next.addr     = r_reg.addr + 14'h0001;
            end else begin
              r_next.wr_stop    = 1'b1;
              r_next.wr_refused = 1'b1;
            end
          end
        end
        sfw_pkg::ST_SWR: begin
          if (byte_done) begin
            r_next.state = sfw_pkg::ST_SKIP;
            if (r_reg.latch && !(r_reg.pen && !pins.wp_n)) begin
              r_next.pen   = sh_v[sfw_pkg::BIT_PEN];
              r_next.guard = {sh_v[sfw_pkg::BIT_GHI], sh_v[sfw_pkg::BIT_GLO]};
              r_next.nv_wr = 1'b1;
            end else begin
              r_next.status_refused = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r_reg <= CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign spi_so             = r_reg.so;
  assign spi_so_oe          = r_reg.so_oe;
  assign array_wr           = r_reg.wr;
  assign array_wr_refused   = r_reg.wr_refused;
  assign status_wr_refused  = r_reg.status_refused;
  assign cmd                = r_reg.cmd;
  assign sleep_req          = r_reg.sleep_req;
  assign nv_guard_wr        = r_reg.nv_wr;
  assign nv_guard_out       = r_reg.guard;
  assign write_latch_flag   = r_reg.latch;
  assign protect_pin_enable = r_reg.pen;

endmodule

// >>> core/sfw_pkg.sv
package sfw_pkg;

  // Command opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_ARRAY_RD  = 8'h03;
  localparam logic [7:0] OP_FAST_RD   = 8'h0B;
  localparam logic [7:0] OP_ARRAY_WR  = 8'h02;
  localparam logic [7:0] OP_SLEEP     = 8'hB9;
  localparam logic [7:0] OP_IDENT     = 8'h9F;

  // Status register field positions
  localparam int BIT_PEN   = 7;
  localparam int BIT_GHI   = 3;
  localparam int BIT_GLO   = 2;
  localparam int BIT_LATCH = 1;
  localparam int BIT_WAKE  = 0;

  // Reset values
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_PEN   = 1'b0;
  localparam logic [1:0] RST_GUARD = 2'h0;

  // Block guard codes and range bases
  localparam logic [1:0]  GUARD_NONE    = 2'h0;
  localparam logic [1:0]  GUARD_QUARTER = 2'h1;
  localparam logic [1:0]  GUARD_HALF    = 2'h2;
  localparam logic [1:0]  GUARD_ALL     = 2'h3;
  localparam int          ADDR_W        = 14;
  localparam logic [13:0] QUARTER_BASE  = 14'h3000;
  localparam logic [13:0] HALF_BASE     = 14'h2000;
  localparam logic [2:0]  BIT_LAST      = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR   = 7'h04,
    ST_WDATA  = 7'h08,
    ST_SRD    = 7'h10,
    ST_SWR    = 7'h20,
    ST_SKIP   = 7'h40
  } sfw_state_t;

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_SET_LATCH = 4'h1,
    CMD_CLR_LATCH = 4'h2,
    CMD_STATUS_RD = 4'h3,
    CMD_STATUS_WR = 4'h4,
    CMD_ARRAY_RD  = 4'h5,
    CMD_FAST_RD   = 4'h6,
    CMD_ARRAY_WR  = 4'h7,
    CMD_SLEEP     = 4'h8,
    CMD_IDENT     = 4'h9,
    CMD_INVALID   = 4'hA
  } sfw_cmd_kind_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
  } sfw_pins_t;

  localparam sfw_pins_t PINS_IDLE = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0,
                                      wp_n: 1'b1};

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } sfw_wr_t;

  typedef struct packed {
    logic          valid;
    sfw_cmd_kind_t kind;
  } sfw_cmd_t;

  typedef struct packed {
    sfw_pins_t meta;
    sfw_pins_t stable;
  } sfw_sync_t;

  typedef struct packed {
    sfw_state_t        state;
    sfw_pins_t         prev;
    logic [2:0]        bit_cnt;
    logic [7:0]        sh_in;
    logic [7:0]        sh_out;
    logic [ADDR_W-1:0] addr;
    logic              addr_lo;
    logic              wr_stop;
    logic              end_clear;
    logic              end_sleep;
    logic              latch;
    logic              pen;
    logic [1:0]        guard;
    logic              nv_loaded;
    logic              so;
    logic              so_oe;
    sfw_wr_t           wr;
    logic              wr_refused;
    logic              status_refused;
    logic              nv_wr;
    sfw_cmd_t          cmd;
    logic              sleep_req;
  } sfw_core_t;

endpackage

// >>> core/sfw_pin_sync.sv
`timescale 1ns/100ps

module sfw_pin_sync (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire sfw_pkg::sfw_pins_t pins_in,
  output sfw_pkg::sfw_pins_t     pins_out
);

  sfw_pkg::sfw_sync_t sync_reg;
  sfw_pkg::sfw_sync_t sync_next;

  // Meta stage feeds only the stable stage
  always_comb begin
    sync_next        = sync_reg;
    sync_next.meta   = pins_in;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync_reg <= '{meta: sfw_pkg::PINS_IDLE, stable: sfw_pkg::PINS_IDLE};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign pins_out = sync_reg.stable;

endmodule

// >>> verification/sfw_core_asserts.sv
`timescale 1ns/100ps
module sfw_core_asserts (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              spi_sck,
  input wire logic              spi_cs_n,
  input wire logic              spi_si,
  input wire logic              protect_pin_n,
  input wire logic              wake_busy,
  input wire logic [1:0]        nv_guard_in,
  input wire logic              spi_so,
  input wire logic              spi_so_oe,
  input wire sfw_pkg::sfw_wr_t  array_wr,
  input wire logic              array_wr_refused,
  input wire logic              status_wr_refused,
  input wire sfw_pkg::sfw_cmd_t cmd,
  input wire logic              sleep_req,
  input wire logic              nv_guard_wr,
  input wire logic [1:0]        nv_guard_out,
  input wire logic              write_latch_flag,
  input wire logic              protect_pin_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic stop_reg;
  logic stop_next;
  function automatic logic guarded(logic [1:0] g, logic [13:0] a);
    return g == 2'h3 || (g == 2'h2 && a >= 14'h2000) ||
      (g == 2'h1 && a >= 14'h3000);
  endfunction
  // Burst stays dead until next opcode
  always_comb begin
    stop_next = stop_reg;
    if (cmd.valid) stop_next = 1'b0;
    if (array_wr_refused) stop_next = 1'b1;
  end
  always_ff @(posedge clock) begin
    if (!reset_n) stop_reg <= 1'b0;
    else stop_reg <= stop_next;
  end
  chk_latch_set: assert property ($rose(write_latch_flag) |->
    cmd.valid && cmd.kind == sfw_pkg::CMD_SET_LATCH)
    else $error("latch rose without set command");
  chk_latch_clear: assert property (cmd.valid &&
    cmd.kind == sfw_pkg::CMD_CLR_LATCH |-> ##[0:1] !write_latch_flag)
    else $error("clear command left latch set");
  chk_latch_fall: assert property ($fell(write_latch_flag) |->
    cmd.kind inside {sfw_pkg::CMD_CLR_LATCH, sfw_pkg::CMD_STATUS_WR,
    sfw_pkg::CMD_ARRAY_WR}) else $error("latch fell after wrong frame");
  chk_wr_latch: assert property (array_wr.valid |->
    write_latch_flag) else $error("array write with latch clear");
  chk_wr_guard: assert property (array_wr.valid |->
    !guarded(nv_guard_out, array_wr.addr)) else $error("guarded write");
  chk_burst_stop: assert property (array_wr.valid |->
    !stop_reg) else $error("write after burst stopped");
  chk_status_latch: assert property (nv_guard_wr ||
    $changed(protect_pin_enable) |-> write_latch_flag)
    else $error("status changed with latch clear");
  chk_status_pin: assert property (nv_guard_wr &&
    $past(protect_pin_enable) |-> $past(protect_pin_n, 3) ||
    $past(protect_pin_n, 5)) else $error("status written with pin low");
  chk_oe_status: assert property (spi_so_oe |->
    cmd.kind == sfw_pkg::CMD_STATUS_RD) else $error("output outside read");
  chk_sleep_req: assert property (sleep_req |->
    cmd.kind == sfw_pkg::CMD_SLEEP) else $error("sleep without opcode");
  cov_array_wr: cover property (array_wr.valid);
  cov_refused: cover property (array_wr_refused);
  cov_status_wr: cover property (nv_guard_wr);
endmodule
bind sfw_core sfw_core_asserts u_chk (.*);

// >>> verification/sfw_spi_master.sv
`timescale 1ns/100ps
module sfw_spi_master (
  output logic     sck,
  output logic     cs_n,
  output logic     si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end
  // Mode 0; si changes while the clock is low, at the falling clock or at the first bit after select falls
  task automatic xfer(input int n, input logic [7:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si <= tx[i];
      #32 sck <= 1'b1;
      rx = {rx[6:0], so};
      #32 sck <= 1'b0;
    end
  endtask
  task automatic open;
    cs_n <= 1'b0;
    #32;
  endtask
  // Gap lets the rising select reach the core
  task automatic close;
    #32 cs_n <= 1'b1;
    #200;
  endtask
endmodule

// >>> verification/sfw_core_tb.sv
`timescale 1ns/100ps
module sfw_core_tb;
  logic              clock = 1'b0;
  logic              reset_n = 1'b0;
  logic              pin_n = 1'b1;
  logic              wake = 1'b0;
  logic [1:0]        nv_in = 2'h0;
  logic              sck, cs_n, si, so, so_oe, a_ref, slp, nv_wr;
  logic              latch, pen;
  logic [1:0]        nv_out;
  logic              s_ref;
  int                sref_n = 0;
  int                nvw_n = 0;
  int                slp_n = 0;
  sfw_pkg::sfw_wr_t  wr;
  sfw_pkg::sfw_cmd_t cmd;
  logic [3:0]        kind = 4'h0;
  logic [13:0]       wr_a = 14'h0000;
  int                wr_n = 0;
  int                ref_n = 0;
  int                err_count = 0;
  int                check_count = 0;
  always #2.5 clock = ~clock;
  sfw_spi_master m (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  sfw_core dut (.clock(clock), .reset_n(reset_n), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_si(si), .protect_pin_n(pin_n),
    .wake_busy(wake), .nv_guard_in(nv_in), .spi_so(so),
    .spi_so_oe(so_oe), .array_wr(wr), .array_wr_refused(a_ref),
    .status_wr_refused(s_ref), .cmd(cmd), .sleep_req(slp),
    .nv_guard_wr(nv_wr), .nv_guard_out(nv_out),
    .write_latch_flag(latch), .protect_pin_enable(pen));
  always @(posedge clock) begin
    if (cmd.valid) kind <= cmd.kind;
    if (wr.valid) wr_n <= wr_n + 1;
    if (wr.valid) wr_a <= wr.addr;
    if (a_ref) ref_n <= ref_n + 1;
    if (s_ref) sref_n <= sref_n + 1;
    if (nv_wr) nvw_n <= nvw_n + 1;
    if (slp) slp_n <= slp_n + 1;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic frm(input logic [7:0] op, input int n, input logic [7:0] d);
    logic [7:0] r;
    m.open;
    m.xfer(8, op, r);
    if (n > 0) m.xfer(n, d, r);
    m.close;
  endtask
  task automatic rd(input logic [7:0] exp);
    logic [7:0] r;
    m.open;
    m.xfer(8, 8'h05, r);
    m.xfer(8, 8'h00, r);
    cmp(so_oe, 1'b1);
    m.close;
    cmp(so_oe, 1'b0);
    cmp(r, exp);
  endtask
  task automatic do_reset(input logic [1:0] g);
    @(posedge clock) reset_n <= 1'b0;
    nv_in <= g;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (20) @(posedge clock);
  endtask
  task automatic t_decode;
    logic [7:0] ops [13] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0B,
      8'h02, 8'hB9, 8'h9F, 8'hC3, 8'hC2, 8'h5A, 8'h5B};
    int s0;
    s0 = slp_n;
    for (int i = 0; i < 13; i++) begin
      frm(ops[i], 0, 8'h00);
      cmp(kind, (i < 9) ? i + 1 : 10);
    end
    cmp(slp_n - s0, 1);
    $display("decode test done");
  endtask
  task automatic t_latch;
    rd(8'h00);
    frm(8'h06, 0, 8'h00);
    cmp(latch, 1'b1);
    rd(8'h02);
    frm(8'h04, 0, 8'h00);
    rd(8'h00);
    @(posedge clock) wake <= 1'b1;
    rd(8'h01);
    @(posedge clock) wake <= 1'b0;
    $display("latch test done");
  endtask
  task automatic t_status;
    int r0;
    int w0;
    r0 = sref_n;
    w0 = nvw_n;
    frm(8'h06, 0, 8'h00);
    frm(8'h01, 8, 8'hFF);
    rd(8'h8C);
    cmp(nv_out, 2'h3);
    @(posedge clock) pin_n <= 1'b0;
    frm(8'h06, 0, 8'h00);
    frm(8'h01, 8, 8'h00);
    rd(8'h8C);
    // pin back high before a status write
    @(posedge clock) pin_n <= 1'b1;
    frm(8'h01, 8, 8'h00);
    rd(8'h8C);
    frm(8'h06, 0, 8'h00);
    frm(8'h01, 5, 8'h00);
    rd(8'h8C);
    frm(8'h06, 0, 8'h00);
    frm(8'h01, 8, 8'h84);
    rd(8'h84);
    cmp(nvw_n - w0, 2);
    cmp(sref_n - r0, 2);
    $display("status test done");
  endtask
  task automatic t_array;
    logic [7:0] r;
    int n0;
    int f0;
    logic [7:0] d [6] = '{8'h02, 8'h2F, 8'hFE, 8'hAA, 8'hBB, 8'hCC};
    @(posedge clock) pin_n <= 1'b0;
    frm(8'h06, 0, 8'h00);
    n0 = wr_n;
    f0 = ref_n;
    m.open;
    foreach (d[i]) m.xfer(8, d[i], r);
    m.xfer(8, 8'hDD, r);
    m.close;
    cmp(wr_n - n0, 2);
    cmp(wr_a, 14'h2FFF);
    cmp(ref_n - f0, 1);
    cmp(latch, 1'b0);
    frm(8'h02, 0, 8'h00);
    m.open;
    m.xfer(8, 8'h02, r);
    m.xfer(8, 8'h00, r);
    m.xfer(8, 8'h00, r);
    m.xfer(8, 8'h11, r);
    m.close;
    cmp(wr_n - n0, 2);
    @(posedge clock) pin_n <= 1'b1;
    $display("array test done");
  endtask
  task automatic t_nv;
    do_reset(2'h2);
    rd(8'h08);
    $display("storage test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
  initial begin
    do_reset(2'h0);
    t_latch;
    t_decode;
    t_status;
    t_array;
    t_nv;
    end_of_test;
  end
endmodule
